//--- logic/coecb_pkg.sv
// shared constants and types for the clock output enable configuration bank
package coecb_pkg;

  // ****************************************************************
  // serial link framing
  // ****************************************************************
  // full write address byte (7-bit target address plus write bit)
  localparam logic [7:0] COECB_TARGET_ADDR = 8'hD2;
  // bit counter value during the acknowledge clock
  localparam logic [3:0] COECB_ACK_CNT = 4'h8;
  // largest data byte count a transfer may carry
  localparam logic [5:0] COECB_MAX_DATA = 6'h20;
  // number of defined configuration bytes
  localparam logic [5:0] COECB_NUM_CFG = 6'h03;

  // ****************************************************************
  // configuration byte indexes and field positions
  // ****************************************************************
  localparam logic [1:0] COECB_MISC_IDX = 2'h0;
  localparam logic [1:0] COECB_MEM_IDX = 2'h1;
  localparam logic [1:0] COECB_PCI_IDX = 2'h2;
  localparam int COECB_SPREAD_BIT = 3;
  localparam int COECB_DOT_BIT = 2;
  localparam int COECB_USB_BIT = 1;
  localparam int COECB_CPU3_BIT = 0;
  localparam int COECB_PCI_LO_BIT = 1;

  // ****************************************************************
  // reset values and writable bit masks
  // ****************************************************************
  localparam logic [7:0] COECB_MISC_RST = 8'h07;
  localparam logic [7:0] COECB_MEM_RST = 8'hFF;
  localparam logic [7:0] COECB_PCI_RST = 8'hFE;
  localparam logic [7:0] COECB_MISC_MASK = 8'h0F;
  localparam logic [7:0] COECB_MEM_MASK = 8'hFF;
  localparam logic [7:0] COECB_PCI_MASK = 8'hFE;

  // ****************************************************************
  // receiver states
  // ****************************************************************
  typedef enum logic [2:0] {
    COECB_IDLE,
    COECB_ADDR,
    COECB_CMD,
    COECB_COUNT,
    COECB_DATA
  } coecb_state_e;

endpackage

//--- logic/coecb_byte_if.sv
// carrier for one received configuration byte crossing from the link clock
`timescale 1ns/1ps
`default_nettype none
interface coecb_byte_if;
  // toggles once per published byte; index and data stay stable between toggles
  logic pub_tgl;
  logic [1:0] pub_idx;
  logic [7:0] pub_data;

  modport link_side (
    output pub_tgl,
    output pub_idx,
    output pub_data
  );

  modport cfg_side (
    input pub_tgl,
    input pub_idx,
    input pub_data
  );
endinterface
`default_nettype wire

//--- logic/coecb_byte_sync.sv
// toggle handshake receiver that brings link bytes into the system clock
`timescale 1ns/1ps
`default_nettype none
module coecb_byte_sync
  import coecb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  coecb_byte_if.cfg_side lnk,
  output logic wr_stb,
  output logic [1:0] wr_idx,
  output logic [7:0] wr_data
);

  logic tgl_meta_r;
  logic tgl_sync_r;
  logic tgl_seen_r;
  logic tgl_edge;

  // ****************************************************************
  // toggle synchroniser
  // ****************************************************************
  // two stages on the toggle only; the first stage feeds nothing else
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tgl_meta_r <= 1'b0;
      tgl_sync_r <= 1'b0;
      tgl_seen_r <= 1'b0;
    end else begin
      tgl_meta_r <= lnk.pub_tgl;
      tgl_sync_r <= tgl_meta_r;
      tgl_seen_r <= tgl_sync_r;
    end
  end

  assign tgl_edge = tgl_sync_r ^ tgl_seen_r;

  // ****************************************************************
  // byte capture
  // ****************************************************************
  // index and data are safe here: the link holds them for a whole byte time
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_stb <= 1'b0;
      wr_idx <= 2'h0;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= tgl_edge;
      if (tgl_edge) begin
        wr_idx <= lnk.pub_idx;
        wr_data <= lnk.pub_data;
      end
    end
  end

  // [R14] one write per byte
  AST_STROBE_SINGLE: assert property (@(posedge clk) disable iff (!rst_b) // [R14]
    wr_stb |=> !wr_stb)
    else $error("write strobe lasted more than one cycle");

endmodule
`default_nettype wire

//--- logic/coecb_top.sv
// serial configuration receiver and clock output enable bank
//
// What this block and its host do
// [R1] bytes arrive in order from byte 0, each byte most significant bit first
// [R2] host writes zero to every unused or reserved bit
// [R3] host clears all initialize-to-zero bits during its setup writes
// [R4] only bytes 0 to 2 are defined; bytes 3 to 7 are sent as zero
// [R5] byte 0 bits 2, 1, 0 enable dot, serial-bus reference and third processor clock
// [R6] byte 0 bit 3 turns spread-spectrum clocking on or off
// [R7] byte 1 bit n enables memory clock output n
// [R8] byte 2 bits 7 to 1 enable peripheral bus clocks 7 to 1
// [R9] a disabled clock output is held low and stops toggling
// [R10] host sets the enables once at power-on; the bench host writes them in nine separate transfers
// [R11] only block writes to the fixed target address are accepted
// [R12] command and count bytes are acknowledged, their values ignored
// [R13] host sends between 1 and 32 data bytes
// [R14] data fills bytes from 0 upward; a stop keeps completed bytes
// [R15] data bytes past byte 2 are acknowledged and thrown away
`timescale 1ns/1ps
`default_nettype none
module coecb_top
  import coecb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic serial_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic cpu_src_clk,
  input wire logic dot_src_clk,
  input wire logic usb_src_clk,
  input wire logic mem_src_clk,
  input wire logic pci_src_clk,
  output logic third_processor_clock_out,
  output logic dot_clock_out,
  output logic usb_ref_clock_out,
  output logic [7:0] memory_clock_out,
  output logic [7:1] peripheral_bus_clock,
  output logic spread_spectrum_on
);

  // ****************************************************************
  // link side declarations
  // ****************************************************************
  coecb_state_e state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [5:0] data_idx_r;
  logic sda_pos_r;
  logic start_n_r;
  logic stop_tgl_r;
  logic stop_used_r;
  logic sda_oe_r;
  logic ack_want;
  logic ack_clock;

  coecb_byte_if lnk_bus ();

  // ****************************************************************
  // system side declarations
  // ****************************************************************
  logic wr_stb;
  logic [1:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] misc_r;
  logic [7:0] mem_r;
  logic [7:0] pci_r;

  // ****************************************************************
  // start and stop detection
  // ****************************************************************
  // a rise of the data line while the link clock is high is a stop and flips
  // this flag; the link clock does not run around a stop, so the data line
  // itself must clock it. it is read much later, at the next start.
  always_ff @(posedge sda_in or negedge rst_b) begin
    if (!rst_b) begin
      stop_tgl_r <= 1'b0;
    end else if (serial_clk) begin
      stop_tgl_r <= ~stop_tgl_r;
    end
  end

  // data line level at each rising link clock edge; idle bus reads high
  always_ff @(posedge serial_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_pos_r <= 1'b1;
    end else begin
      sda_pos_r <= sda_in;
    end
  end

  // [R11] start seen at falling edge
  // a high-to-low data change inside a clock high phase is a start; a
  // start that follows a stop is caught by a flipped stop flag; the flip is
  // used up at once so a low first bit cannot look like a second start
  always_ff @(negedge serial_clk or negedge rst_b) begin
    if (!rst_b) begin
      start_n_r <= 1'b0;
      stop_used_r <= 1'b0;
    end else begin
      start_n_r <= !sda_in && (sda_pos_r || (stop_tgl_r != stop_used_r));
      stop_used_r <= stop_tgl_r;
    end
  end

  // ****************************************************************
  // bit shifter
  // ****************************************************************
  assign ack_clock = (bit_cnt_r == COECB_ACK_CNT);

  // [R1] msb first shift
  // bits are taken on the rising link clock, the first one is bit 7
  always_ff @(posedge serial_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
    end else if (start_n_r) begin
      bit_cnt_r <= 4'h1;
      shift_r <= {7'h00, sda_in};
    end else if (ack_clock) begin
      bit_cnt_r <= 4'h0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      shift_r <= {shift_r[6:0], sda_in};
    end
  end

  // ****************************************************************
  // transfer sequencing
  // ****************************************************************
  // [R11] address match gates transfer
  // [R12] command then count
  // every step after the start is taken at the acknowledge clock; a foreign address parks
  // the receiver in idle until the next start
  always_ff @(posedge serial_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= COECB_IDLE;
    end else if (start_n_r) begin
      state_r <= COECB_ADDR;
    end else if (ack_clock) begin
      case (state_r)
        COECB_IDLE: begin
          state_r <= COECB_IDLE;
        end
        COECB_ADDR: begin
          state_r <= (shift_r == COECB_TARGET_ADDR) ? COECB_CMD : COECB_IDLE;
        end
        COECB_CMD: begin
          state_r <= COECB_COUNT;
        end
        COECB_COUNT: begin
          state_r <= COECB_DATA;
        end
        COECB_DATA: begin
          state_r <= COECB_DATA;
        end
        default: begin
          state_r <= COECB_IDLE;
        end
      endcase
    end
  end

  // [R14] consecutive byte index
  // the index saturates so an overlong transfer cannot wrap onto byte 0
  always_ff @(posedge serial_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_idx_r <= 6'h00;
    end else if (start_n_r) begin
      data_idx_r <= 6'h00;
    end else if (ack_clock && state_r == COECB_DATA) begin
      if (data_idx_r < COECB_MAX_DATA) begin
        data_idx_r <= data_idx_r + 6'h01;
      end
    end
  end

  // ****************************************************************
  // byte publication toward the system clock
  // ****************************************************************
  // [R14] commit each complete byte
  // [R15] discard bytes past byte 2
  // a byte counts once its eighth bit is in; a stop afterwards keeps it
  always_ff @(posedge serial_clk or negedge rst_b) begin
    if (!rst_b) begin
      lnk_bus.pub_tgl <= 1'b0;
      lnk_bus.pub_idx <= 2'h0;
      lnk_bus.pub_data <= 8'h00;
    end else if (!start_n_r && ack_clock && state_r == COECB_DATA
                 && data_idx_r < COECB_NUM_CFG) begin
      lnk_bus.pub_tgl <= ~lnk_bus.pub_tgl;
      lnk_bus.pub_idx <= data_idx_r[1:0];
      lnk_bus.pub_data <= shift_r;
    end
  end

  // ****************************************************************
  // acknowledge drive
  // ****************************************************************
  // [R12] acknowledge command and count
  // [R15] acknowledge discarded data
  always_comb begin
    case (state_r)
      COECB_IDLE: ack_want = 1'b0;
      COECB_ADDR: ack_want = (shift_r == COECB_TARGET_ADDR);
      COECB_CMD: ack_want = 1'b1;
      COECB_COUNT: ack_want = 1'b1;
      COECB_DATA: ack_want = 1'b1;
      default: ack_want = 1'b0;
    endcase
  end

  // pull low from the falling edge after bit 0 until the falling edge
  // that ends the acknowledge clock, so the line is steady while high
  always_ff @(negedge serial_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_oe_r <= 1'b0;
    end else begin
      sda_oe_r <= ack_clock && ack_want && !start_n_r;
    end
  end

  assign sda_out = 1'b0; // open drain: only ever pulls low
  assign sda_oe = sda_oe_r;

  // ****************************************************************
  // crossing into the system clock
  // ****************************************************************
  coecb_byte_sync u_byte_sync (
    .clk(clk),
    .rst_b(rst_b),
    .lnk(lnk_bus.cfg_side),
    .wr_stb(wr_stb),
    .wr_idx(wr_idx),
    .wr_data(wr_data)
  );

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  // [R4] reserved bits stored as zero
  // [R5] misc byte fields
  // [R6] spread control bit
  // reserved bits are masked so a careless host cannot reach test modes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      misc_r <= COECB_MISC_RST;
    end else if (wr_stb && wr_idx == COECB_MISC_IDX) begin
      misc_r <= wr_data & COECB_MISC_MASK;
    end
  end

  // [R7] memory clock enables
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mem_r <= COECB_MEM_RST;
    end else if (wr_stb && wr_idx == COECB_MEM_IDX) begin
      mem_r <= wr_data & COECB_MEM_MASK;
    end
  end

  // [R8] peripheral clock enables
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pci_r <= COECB_PCI_RST;
    end else if (wr_stb && wr_idx == COECB_PCI_IDX) begin
      pci_r <= wr_data & COECB_PCI_MASK;
    end
  end

  // ****************************************************************
  // output gating
  // ****************************************************************
  // [R9] disabled outputs held low
  // plain and-gating: an enable changed while a source is high can cut a
  // short pulse, acceptable because enables are set once at power-on
  assign third_processor_clock_out = cpu_src_clk & misc_r[COECB_CPU3_BIT];
  assign dot_clock_out = dot_src_clk & misc_r[COECB_DOT_BIT];
  assign usb_ref_clock_out = usb_src_clk & misc_r[COECB_USB_BIT];
  assign memory_clock_out = {8{mem_src_clk}} & mem_r;
  assign peripheral_bus_clock = {7{pci_src_clk}} & pci_r[7:COECB_PCI_LO_BIT];
  assign spread_spectrum_on = misc_r[COECB_SPREAD_BIT];

  // ****************************************************************
  // link side checks
  // ****************************************************************
  AST_MSB_FIRST: assert property (@(posedge serial_clk) disable iff (!rst_b) // [R1]
    (!start_n_r && bit_cnt_r == 4'h7)
      |=> (shift_r[7:1] == $past(shift_r[6:0]) && shift_r[0] == $past(sda_in)))
    else $error("bit 0 not shifted in last");

  AST_FOREIGN_NO_ACK: assert property (@(negedge serial_clk) disable iff (!rst_b) // [R11]
    (state_r == COECB_ADDR && ack_clock && shift_r != COECB_TARGET_ADDR) |=> !sda_oe)
    else $error("foreign address acknowledged");

  AST_HEADER_ACK: assert property (@(negedge serial_clk) disable iff (!rst_b) // [R12]
    (!start_n_r && ack_clock && (state_r == COECB_CMD || state_r == COECB_COUNT))
      |=> sda_oe ##1 !sda_oe)
    else $error("command or count byte not acknowledged for one clock");

  AST_EXTRA_DISCARD: assert property (@(posedge serial_clk) disable iff (!rst_b) // [R15]
    (state_r == COECB_DATA && ack_clock && data_idx_r >= COECB_NUM_CFG)
      |=> $stable(lnk_bus.pub_tgl))
    else $error("byte past the bank was published");

  AST_DATA_PUBLISH: assert property (@(posedge serial_clk) disable iff (!rst_b) // [R14]
    (!start_n_r && state_r == COECB_DATA && ack_clock && data_idx_r < COECB_NUM_CFG)
      |=> (lnk_bus.pub_tgl != $past(lnk_bus.pub_tgl)
           && lnk_bus.pub_idx == $past(data_idx_r[1:0])))
    else $error("complete byte not published at its index");

  // ****************************************************************
  // system side checks
  // ****************************************************************
  AST_SPREAD_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
    (wr_stb && wr_idx == COECB_MISC_IDX)
      |=> spread_spectrum_on == $past(wr_data[COECB_SPREAD_BIT]))
    else $error("spread control did not follow byte 0 bit 3");

  AST_MISC_FIELDS: assert property (@(posedge clk) disable iff (!rst_b) // [R5]
    (wr_stb && wr_idx == COECB_MISC_IDX)
      |=> (misc_r[2:0] == $past(wr_data[2:0]) && misc_r[7:4] == 4'h0))
    else $error("byte 0 enables or reserved bits wrong");

  AST_MEM_FIELDS: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
    (wr_stb && wr_idx == COECB_MEM_IDX) |=> mem_r == $past(wr_data))
    else $error("memory clock enables not taken from byte 1");

  AST_PCI_FIELDS: assert property (@(posedge clk) disable iff (!rst_b) // [R8]
    (wr_stb && wr_idx == COECB_PCI_IDX)
      |=> (pci_r[7:1] == $past(wr_data[7:1]) && !pci_r[0]))
    else $error("peripheral clock enables not taken from byte 2");

  AST_GATED_LOW: assert property (@(posedge clk) disable iff (!rst_b) // [R9]
    ((memory_clock_out & ~mem_r) == 8'h00 && (peripheral_bus_clock & ~pci_r[7:1]) == 7'h00))
    else $error("disabled clock output not low");

endmodule
`default_nettype wire

//--- tb/coecb_host.sv
// host model that writes the configuration bytes over the two-wire link
`timescale 1ns/1ps
`default_nettype none
module coecb_host (
  output logic serial_clk,
  output logic sda_pull,
  input wire logic sda_line
);
  // link idles with clock high and data released to the pull-up
  initial begin
    serial_clk = 1'b1;
    sda_pull = 1'b0;
  end

  // most significant first
  // fewer than eight bits leaves the byte unfinished, so no ack clock is given
  task automatic put(input logic [7:0] d, input int n, output logic ack);
    ack = 1'b0;
    for (int i = 0; i < n; i++) begin
      sda_pull = ~d[7-i];
      #40 serial_clk = 1'b1;
      #80 serial_clk = 1'b0;
      #40;
    end
    if (n == 8) begin
      sda_pull = 1'b0;
      #40 serial_clk = 1'b1;
      #40 ack = ~sda_line;
      #40 serial_clk = 1'b0;
      #40;
    end
  endtask

  // address, zero command, count, then bytes from byte 0 up
  // the bench supplies zeros for reserved bits and trailing bytes
  task automatic xfer(input logic [7:0] adr, input logic [7:0] dat[8], input int nd,
      input int tail, output logic [10:0] ack);
    logic a;
    ack = '0;
    sda_pull = 1'b1;
    #80 serial_clk = 1'b0;
    #40;
    put(adr, 8, ack[10]);
    put(8'h00, 8, ack[9]);
    put(nd[7:0], 8, ack[8]);
    for (int k = 0; k < nd; k++) begin
      put(dat[k], 8, ack[7-k]);
    end
    if (tail > 0) begin
      put(dat[nd], tail, a);
    end
    // stop: data rises while the clock is high
    sda_pull = 1'b1;
    #40 serial_clk = 1'b1;
    #40 sda_pull = 1'b0;
    #80;
  endtask
endmodule
`default_nettype wire

//--- tb/test_clock_output_enable_config_bank.sv
// self-checking bench for the clock output enable configuration bank
`timescale 1ns/1ps
`default_nettype none
module test_clock_output_enable_config_bank;
  logic clk = 1'b0;
  logic rst_b;
  logic src;
  logic serial_clk, sda_pull, sda_out, sda_oe, sda_line;
  logic cpu_o, dot_o, usb_o, spread_o;
  logic [7:0] mem_o;
  logic [7:1] pci_o;
  logic [23:0] cfg_seen;
  logic [10:0] ack;
  logic [7:0] dat[8];
  int num_errors = 0;
  int tests_run = 0;
  // rows: bytes sent 0..2, then bytes expected at the outputs
  logic [47:0] rows[6] = '{48'h000000_000000, 48'h0FFFFE_0FFFFE, 48'h08A55A_08A55A,
    48'h053C82_053C82, 48'h028124_028124, 48'h06C302_06C302};

  always #50 clk = ~clk;

  // open-drain line: low if either party pulls, else the pull-up wins
  assign sda_line = (sda_oe ? sda_out : 1'b1) & ~sda_pull;
  assign cfg_seen = {4'h0, spread_o, dot_o, usb_o, cpu_o, mem_o, pci_o, 1'b0};

  coecb_host i_host (.serial_clk(serial_clk), .sda_pull(sda_pull), .sda_line(sda_line));

  coecb_top i_dut (
    .clk(clk), .rst_b(rst_b), .serial_clk(serial_clk), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .cpu_src_clk(src), .dot_src_clk(src),
    .usb_src_clk(src), .mem_src_clk(src), .pci_src_clk(src),
    .third_processor_clock_out(cpu_o), .dot_clock_out(dot_o), .usb_ref_clock_out(usb_o),
    .memory_clock_out(mem_o), .peripheral_bus_clock(pci_o), .spread_spectrum_on(spread_o)
  );

  // ****************************************************************
  // compare and helper tasks
  // ****************************************************************
  task automatic cmp_cfg(input string nm, input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_ack(input string nm, input logic [10:0] e, input logic [10:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // sources high show the enables, sources low must leave every clock output low while spread_spectrum_on keeps its value
  task automatic see(input string nm, input logic [23:0] e);
    repeat (6) @(negedge clk);
    src = 1'b1;
    @(negedge clk);
    cmp_cfg(nm, e, cfg_seen);
    src = 1'b0;
    @(negedge clk);
    cmp_cfg(nm, e & 24'h080000, cfg_seen);
    $display("test %s done", nm);
  endtask

  task automatic fill(input logic [23:0] b);
    dat = '{b[23:16], b[15:8], b[7:0], 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  endtask

  task automatic results();
    $display("tests_run %0d num_errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rst_b = 1'b0;
    src = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    for (int r = 0; r < 6; r++) begin
      fill(rows[r][47:24]);
      i_host.xfer(8'hD2, dat, 3, 0, ack);
      cmp_ack("row ack", 11'h7E0, ack);
      see("row", rows[r][23:0]);
    end
    // trailing reserved bytes are taken and dropped
    fill(24'h0A5AA4);
    i_host.xfer(8'hD2, dat, 8, 0, ack);
    cmp_ack("long ack", 11'h7FF, ack);
    see("long", 24'h0A5AA4);
    // a single byte leaves bytes 1 and 2 alone
    fill(24'h010000);
    i_host.xfer(8'hD2, dat, 1, 0, ack);
    cmp_ack("short ack", 11'h780, ack);
    see("short", 24'h015AA4);
    // stop in the middle of byte 1 drops that byte
    fill(24'h03FF00);
    i_host.xfer(8'hD2, dat, 1, 4, ack);
    cmp_ack("cut ack", 11'h780, ack);
    see("cut", 24'h035AA4);
    // foreign address gets no acknowledge and changes nothing
    fill(24'h000000);
    i_host.xfer(8'hD4, dat, 3, 0, ack);
    cmp_ack("foreign ack", 11'h000, ack);
    see("foreign", 24'h035AA4);
    // second reset in mid-run restores the chosen defaults
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    cmp_ack("oe after reset", 11'h000, {10'h000, sda_oe});
    see("reset", 24'h07FFFE);
    results();
  end

  // watchdog: all transfers need well under a third of this span
  initial begin
    #1000000;
    num_errors++;
    results();
  end
endmodule
`default_nettype wire
